// file: rtl/smart_dac_regs.v
`timescale 1ns/10ps
`include "smart_dac_map.vh"
module smart_dac_regs #(
   parameter W        = 10,
   parameter PART_ID  = 4'h9, // arbitrary value
   parameter REV_ID   = 2'h0, // arbitrary value
   parameter T_4M9152 = `NS_TO_CYC(`T_4M9152_NS),
   parameter T_3M2768 = `NS_TO_CYC(`T_3M2768_NS),
   parameter T_2M4576 = `NS_TO_CYC(`T_2M4576_NS),
   parameter T_1M6384 = `NS_TO_CYC(`T_1M6384_NS),
   parameter T_358U4  = `NS_TO_CYC(`T_358U4_NS),
   parameter T_307U2  = `NS_TO_CYC(`T_307U2_NS),
   parameter T_256U   = `NS_TO_CYC(`T_256U_NS),
   parameter T_204U8  = `NS_TO_CYC(`T_204U8_NS)
) (
   input  wire          sys_clk,
   input  wire          resetn,
   input  wire          wr_en,
   input  wire          rd_en,
   input  wire [7:0]    addr,
   input  wire [15:0]   wdata,
   input  wire          user_crc_err,
   input  wire          factory_crc_err,
   input  wire          store_active,
   input  wire          gen_run,
   output reg  [15:0]   rdata_r,
   output reg           rvalid_r,
   output reg  [W-1:0]  code_r,
   output reg           update_busy_r,
   output reg           pmbus_en_r,
   output reg           out_on_r,
   output reg           out_gnd_r,
   output reg           out_hiz_r,
   output reg           ref_int_r,
   output reg  [2:0]    gain_r,
   output reg           locked_r
);
   // short step intervals in cycles, cut to the timer width where used
   localparam C25U6 = `NS_TO_CYC(`T_25U6_NS);
   localparam C32U  = `NS_TO_CYC(`T_32U_NS);
   localparam C38U4 = `NS_TO_CYC(`T_38U4_NS);
   localparam C44U8 = `NS_TO_CYC(`T_44U8_NS);
   localparam C12U  = `NS_TO_CYC(`T_12U_NS);
   localparam C8U   = `NS_TO_CYC(`T_8U_NS);
   localparam C4U   = `NS_TO_CYC(`T_4U_NS);
   // generator states, one-hot
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_UP   = 3'b010;
   localparam [2:0] S_DOWN = 3'b100;

   reg  [15:0]  gen_r;
   reg          unlock_r;
   reg  [2:0]   st_r;
   reg  [2:0]   st_nxt;
   reg  [W-1:0] code_nxt;
   reg  [17:0]  tmr_r;
   reg  [17:0]  intv_cyc;
   reg  [5:0]   step;
   reg  [W:0]   up_sum;
   reg  [W:0]   dn_dif;
   wire [W-1:0] upper_code;
   wire [W-1:0] lower_code;
   wire         busy;
   wire         wr_ok;
   wire         lim_wr;
   wire [1:0]   wave;
   wire [3:0]   intv;
   wire [2:0]   stsel;
   wire         tick;

   assign busy  = store_active | update_busy_r;
   assign wr_ok = wr_en & ~busy & (~gen_r[`BIT_LOCK] | unlock_r);
   assign lim_wr = wr_ok & ((addr == `ADDR_UPPER_LIMIT) | (addr == `ADDR_LOWER_LIMIT));
   assign wave  = gen_r[`FLD_WAVE_HI:`FLD_WAVE_LO];
   assign intv  = gen_r[`FLD_INTV_HI:`FLD_INTV_LO];
   assign stsel = gen_r[`FLD_STEP_HI:`FLD_STEP_LO];
   assign tick  = (tmr_r == 18'h00000);

   // limit code store, codes in bits 11..2
   limit_store #(.W(W)) u_lim (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .wr_en   (lim_wr),
      .wr_sel  (addr == `ADDR_LOWER_LIMIT),
      .wr_data (wdata[W+1:2]),
      .upper_r (upper_code),
      .lower_r (lower_code)
   );

   // general settings and unlock key
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gen_r    <= `GENERAL_RESET;
         unlock_r <= 1'b0;
      end else begin
         if (wr_en & ~busy & (addr == `ADDR_TRIGGER))
            unlock_r <= (wdata[`FLD_KEY_HI:`FLD_KEY_LO] == `UNLOCK_KEY);
         if (wr_ok & (addr == `ADDR_GENERAL))
            gen_r <= wdata;
      end
   end

   // increment decode
   always @* begin
      case (stsel)
         3'd0:    step = 6'd1;
         3'd1:    step = 6'd2;
         3'd2:    step = 6'd3;
         3'd3:    step = 6'd4;
         3'd4:    step = 6'd6;
         3'd5:    step = 6'd8;
         3'd6:    step = 6'd16;
         default: step = 6'd32;
      endcase
   end

   // interval decode in cycles
   always @* begin
      case (intv)
         4'h0:    intv_cyc = C25U6[17:0];
         4'h1:    intv_cyc = C32U[17:0];
         4'h2:    intv_cyc = C38U4[17:0];
         4'h3:    intv_cyc = C44U8[17:0];
         4'h4:    intv_cyc = T_204U8[17:0];
         4'h5:    intv_cyc = T_256U[17:0];
         4'h6:    intv_cyc = T_307U2[17:0];
         4'h7:    intv_cyc = T_358U4[17:0];
         4'h8:    intv_cyc = T_1M6384[17:0];
         4'h9:    intv_cyc = T_2M4576[17:0];
         4'ha:    intv_cyc = T_3M2768[17:0];
         4'hb:    intv_cyc = T_4M9152[17:0];
         4'hc:    intv_cyc = C12U[17:0];
         4'hd:    intv_cyc = C8U[17:0];
         4'he:    intv_cyc = C4U[17:0];
         default: intv_cyc = 18'h00001;
      endcase
   end

   // next code and state of the waveform generator
   always @* begin
      up_sum   = {1'b0, code_r} + {{(W-5){1'b0}}, step};
      dn_dif   = {1'b0, code_r} - {{(W-5){1'b0}}, step};
      st_nxt   = st_r;
      code_nxt = code_r;
      case (st_r)
         S_IDLE: begin
            if (gen_run) begin
               st_nxt   = (wave == 2'b10) ? S_DOWN : S_UP;
               code_nxt = (wave == 2'b10) ? upper_code : lower_code;
            end
         end
         S_UP: begin
            if (wave == 2'b11) begin
               code_nxt = upper_code;
               st_nxt   = S_DOWN;
            end else if (up_sum >= {1'b0, upper_code}) begin
               code_nxt = upper_code;
               if (wave == 2'b01)
                  st_nxt = S_IDLE;
               else
                  st_nxt = S_DOWN;
            end else begin
               code_nxt = up_sum[W-1:0];
            end
         end
         S_DOWN: begin
            if (wave == 2'b11) begin
               code_nxt = lower_code;
               st_nxt   = S_UP;
            end else if (dn_dif[W] | (dn_dif <= {1'b0, lower_code})) begin
               code_nxt = lower_code;
               if (wave == 2'b10)
                  st_nxt = S_IDLE;
               else
                  st_nxt = S_UP;
            end else begin
               code_nxt = dn_dif[W-1:0];
            end
         end
         default: begin
            st_nxt = S_IDLE;
         end
      endcase
   end

   // generator registers, step once per interval
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r          <= S_IDLE;
         code_r        <= {W{1'b0}};
         tmr_r         <= 18'h00000;
         update_busy_r <= 1'b0;
      end else begin
         if (!gen_run) begin
            st_r  <= S_IDLE;
            tmr_r <= 18'h00000;
         end else if (tick) begin
            st_r  <= st_nxt;
            code_r <= code_nxt;
            tmr_r <= intv_cyc - 18'h00001;
         end else begin
            tmr_r <= tmr_r - 18'h00001;
         end
         update_busy_r <= gen_run & tick & (code_nxt != code_r);
      end
   end

   // decoded controls and read port
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r    <= 16'h0000;
         rvalid_r   <= 1'b0;
         pmbus_en_r <= 1'b0;
         out_on_r   <= 1'b0;
         out_gnd_r  <= 1'b0;
         out_hiz_r  <= 1'b1;
         ref_int_r  <= 1'b0;
         gain_r     <= 3'd0;
         locked_r   <= 1'b0;
      end else begin
         pmbus_en_r <= gen_r[`BIT_PMBUS];
         out_on_r   <= (gen_r[`FLD_SHDN_HI:`FLD_SHDN_LO] == 2'b00);
         out_gnd_r  <= gen_r[`FLD_SHDN_LO];
         out_hiz_r  <= (gen_r[`FLD_SHDN_HI:`FLD_SHDN_LO] == 2'b10);
         ref_int_r  <= gen_r[`BIT_REF_EN];
         // gain code: 0 none (supply), 1..4 = 1.5x,2x,3x,4x
         gain_r     <= gen_r[`BIT_REF_EN] ? {1'b0, gen_r[`FLD_GAIN_HI:`FLD_GAIN_LO]} + 3'd1 : 3'd0;
         locked_r   <= gen_r[`BIT_LOCK] & ~unlock_r;
         rvalid_r   <= rd_en;
         if (rd_en) begin
            case (addr)
               `ADDR_STATUS:      rdata_r <= {user_crc_err, factory_crc_err, store_active, update_busy_r,
                                              6'h00, PART_ID, REV_ID};
               `ADDR_GENERAL:     rdata_r <= gen_r;
               `ADDR_UPPER_LIMIT: rdata_r <= {{(14-W){1'b0}}, upper_code, 2'b00};
               `ADDR_LOWER_LIMIT: rdata_r <= {{(14-W){1'b0}}, lower_code, 2'b00};
               default:           rdata_r <= 16'h0000;
            endcase
         end
      end
   end
endmodule // smart_dac_regs

// file: rtl/smart_dac_map.vh
`ifndef SMART_DAC_MAP_VH
`define SMART_DAC_MAP_VH
`define ADDR_STATUS        8'hd0
`define ADDR_GENERAL       8'hd1
`define ADDR_TRIGGER       8'hd3
`define ADDR_UPPER_LIMIT   8'h25
`define ADDR_LOWER_LIMIT   8'h26
`define GENERAL_RESET      16'h01f0
`define BIT_USER_FAULT     15
`define BIT_FACTORY_FAULT  14
`define BIT_STORE_BUSY     13
`define BIT_UPDATE_BUSY    12
`define FLD_WAVE_HI        15
`define FLD_WAVE_LO        14
`define BIT_LOCK           13
`define BIT_PMBUS          12
`define FLD_STEP_HI        11
`define FLD_STEP_LO        9
`define FLD_INTV_HI        8
`define FLD_INTV_LO        5
`define FLD_SHDN_HI        4
`define FLD_SHDN_LO        3
`define BIT_REF_EN         2
`define FLD_GAIN_HI        1
`define FLD_GAIN_LO        0
`define FLD_KEY_HI         15
`define FLD_KEY_LO         12
`define UNLOCK_KEY         4'h5
`define INTV_NO_SLEW       4'hf
`define CLK_MHZ            25
// step intervals in nanoseconds
`define T_25U6_NS   25600
`define T_32U_NS    32000
`define T_38U4_NS   38400
`define T_44U8_NS   44800
`define T_204U8_NS  204800
`define T_256U_NS   256000
`define T_307U2_NS  307200
`define T_358U4_NS  358400
`define T_1M6384_NS 1638400
`define T_2M4576_NS 2457600
`define T_3M2768_NS 3276800
`define T_4M9152_NS 4915200
`define T_12U_NS    12000
`define T_8U_NS     8000
`define T_4U_NS     4000
`define NS_TO_CYC(t) (((t) * `CLK_MHZ) / 1000)
`endif

// file: rtl/limit_store.v
`timescale 1ns/10ps
// two-entry limit code store with registered read
module limit_store #(
   parameter W = 10
) (
   input  wire         sys_clk,
   input  wire         resetn,
   input  wire         wr_en,
   input  wire         wr_sel,
   input  wire [W-1:0] wr_data,
   output reg  [W-1:0] upper_r,
   output reg  [W-1:0] lower_r
);
   // entry 0 upper, entry 1 lower
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         upper_r <= {W{1'b0}};
         lower_r <= {W{1'b0}};
      end else if (wr_en) begin
         if (wr_sel)
            lower_r <= wr_data;
         else
            upper_r <= wr_data;
      end
   end
endmodule // limit_store

// file: dv/smart_dac_checker_properties.sv
`timescale 1ns/10ps
module smart_dac_checker #(
   parameter W       = 10,
   parameter PART_ID = 4'h0,
   parameter REV_ID  = 2'h0
) (
   input wire        sys_clk,
   input wire        resetn,
   input wire        wr_en,
   input wire        rd_en,
   input wire [7:0]  addr,
   input wire        user_crc_err,
   input wire        factory_crc_err,
   input wire        store_active,
   input wire        update_busy_r,
   input wire [W-1:0] code_r,
   input wire [15:0] rdata_r,
   input wire        rvalid_r,
   input wire        pmbus_en_r,
   input wire        out_on_r,
   input wire        out_gnd_r,
   input wire        out_hiz_r,
   input wire        ref_int_r,
   input wire [2:0]  gain_r,
   input wire        locked_r
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // status read request and the decoded settings as one word
   wire       st_rd = rd_en && addr == 8'hd0;
   wire [7:0] dec   = {pmbus_en_r, out_on_r, out_gnd_r, out_hiz_r, ref_int_r, gain_r};
   a_read_valid: assert property (rd_en |=> rvalid_r) else $error("read answer missing");
   a_valid_pulse: assert property (!rd_en |=> !rvalid_r) else $error("read valid without request");
   a_user_fault: assert property (st_rd |=> rdata_r[15] == $past(user_crc_err)) else $error("user fault bit");
   a_factory_fault: assert property (st_rd |=> rdata_r[14] == $past(factory_crc_err)) else $error("factory bit");
   a_store_busy: assert property (st_rd |=> rdata_r[13] == $past(store_active)) else $error("store busy bit");
   a_ident_fields: assert property (st_rd |=> rdata_r[11:0] == {6'h00, PART_ID[3:0], REV_ID[1:0]})
      else $error("identifier fields wrong");
   a_shdn_onehot: assert property ($onehot({out_on_r, out_gnd_r, out_hiz_r})) else $error("shutdown decode");
   a_gain_span: assert property (ref_int_r ? (gain_r >= 3'd1 && gain_r <= 3'd4) : gain_r == 3'd0)
      else $error("gain decode");
   a_store_refuse: assert property (store_active && wr_en && addr == 8'hd1 |-> ##2 $stable(dec))
      else $error("write taken while store busy");
   a_lock_hold: assert property (locked_r && wr_en && addr == 8'hd1 |-> ##2 $stable(dec))
      else $error("write taken while locked");
   a_reset_hiz: assert property ($rose(resetn) |-> out_hiz_r && !out_on_r) else $error("reset shutdown");
   a_update_flag: assert property (update_busy_r == $changed(code_r)) else $error("update flag");
endmodule // smart_dac_checker

bind smart_dac_regs smart_dac_checker #(.W(W), .PART_ID(PART_ID), .REV_ID(REV_ID)) i_smart_dac_checker (
   .sys_clk(sys_clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
   .user_crc_err(user_crc_err), .factory_crc_err(factory_crc_err), .store_active(store_active),
   .rdata_r(rdata_r), .rvalid_r(rvalid_r), .pmbus_en_r(pmbus_en_r), .out_on_r(out_on_r),
   .out_gnd_r(out_gnd_r), .out_hiz_r(out_hiz_r), .ref_int_r(ref_int_r), .gain_r(gain_r), .locked_r(locked_r),
   .update_busy_r(update_busy_r), .code_r(code_r));

// file: dv/smart_dac_host.sv
`timescale 1ns/10ps
module smart_dac_host (
   input  wire        sys_clk,
   input  wire [15:0] rdata_r,
   output reg         wr_en,
   output reg         rd_en,
   output reg  [7:0]  addr,
   output reg  [15:0] wdata
);
   // idle bus at time zero
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr  = 8'h00;
      wdata = 16'h0000;
   end
   // one-cycle write; caller keeps store and generator idle first
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge sys_clk);
         wr_en <= 1'b1;
         addr  <= a;
         wdata <= d;
         @(posedge sys_clk);
         wr_en <= 1'b0;
         addr  <= ~a; // released lines show the inverse
         wdata <= ~d;
      end
   endtask
   // one-cycle read, word taken once settled
   task rd(input [7:0] a, output [15:0] d);
      begin
         @(posedge sys_clk);
         rd_en <= 1'b1;
         addr  <= a;
         @(posedge sys_clk);
         rd_en <= 1'b0;
         addr  <= ~a;
         @(negedge sys_clk);
         d = rdata_r;
      end
   endtask
endmodule // smart_dac_host

// file: dv/smart_dac_status_config_regs_tb.sv
`timescale 1ns/10ps
module smart_dac_status_config_regs_tb;
   localparam PID = 4'ha; // arbitrary value
   localparam RID = 2'h1; // arbitrary value
   localparam TL  = 30;
   reg        sys_clk = 1'b0, resetn = 1'b0, user_crc_err = 1'b0, factory_crc_err = 1'b0;
   reg        store_active = 1'b0, gen_run = 1'b0;
   reg [31:0] s = 32'h3a60;
   reg [15:0] d;
   wire       wr_en, rd_en, rvalid_r, update_busy_r, pmbus_en_r, out_on_r, out_gnd_r, out_hiz_r, ref_int_r, locked_r;
   wire [7:0] addr;
   wire [15:0] wdata, rdata_r;
   wire [9:0] code_r;
   wire [2:0] gain_r;
   integer    miscompares = 0, samples_checked = 0, g = 16'h01f0, k, n, c, p, inc, bad, sh, sl;
   initial forever #20 sys_clk = ~sys_clk;
   smart_dac_regs #(.PART_ID(PID), .REV_ID(RID), .T_4M9152(TL)) i_smart_dac_regs (
      .sys_clk(sys_clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .user_crc_err(user_crc_err), .factory_crc_err(factory_crc_err), .store_active(store_active),
      .gen_run(gen_run), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .code_r(code_r), .update_busy_r(update_busy_r),
      .pmbus_en_r(pmbus_en_r), .out_on_r(out_on_r), .out_gnd_r(out_gnd_r), .out_hiz_r(out_hiz_r),
      .ref_int_r(ref_int_r), .gain_r(gain_r), .locked_r(locked_r));
   smart_dac_host i_smart_dac_host (.sys_clk(sys_clk), .rdata_r(rdata_r), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata));
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task rdc(input [7:0] a, input [15:0] e);
      begin
         i_smart_dac_host.rd(a, d);
         check(d, e);
      end
   endtask
   // decoded outputs against the settings model
   task chk_dec;
      begin
         repeat (3) @(negedge sys_clk);
         check({pmbus_en_r, out_on_r, out_gnd_r, out_hiz_r, ref_int_r, gain_r}, {g[12], g[4:3] == 2'b00, g[3],
            g[4:3] == 2'b10, g[2], g[2] ? {1'b0, g[1:0]} + 3'd1 : 3'd0});
      end
   endtask
   task run_gen(input on);
      begin
         @(posedge sys_clk);
         gen_run <= on;
         repeat (4) @(negedge sys_clk);
      end
   endtask
   task end_of_test;
      begin
         $display("checked %0d miscompares %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #(40 * 20000);
      miscompares = miscompares + 1;
      end_of_test;
   end
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc(8'hd1, 16'h01f0);
      chk_dec;
      rdc(8'h40, 16'h0000);
      for (k = 0; k < 8; k = k + 1) begin
         @(posedge sys_clk);
         {user_crc_err, factory_crc_err, store_active} <= k[2:0];
         rdc(8'hd0, {k[2:0], 7'h00, PID, RID});
      end
      i_smart_dac_host.wr(8'hd1, 16'h0000);
      rdc(8'hd1, 16'h01f0);
      @(posedge sys_clk);
      {user_crc_err, factory_crc_err, store_active} <= 3'b000;
      // byte swap mixes high bits into the shutdown, reference and gain fields
      for (k = 0; k < 8; k = k + 1) begin
         s = lfsr(s);
         g = (s[15:0] ^ {s[7:0], s[15:8]}) & 16'hdfff;
         i_smart_dac_host.wr(8'hd1, g[15:0]);
         chk_dec;
         rdc(8'hd1, g[15:0]);
      end
      g = 16'h21f0;
      i_smart_dac_host.wr(8'hd1, 16'h21f0);
      i_smart_dac_host.wr(8'hd1, 16'h0000);
      chk_dec;
      check(locked_r, 1'b1);
      rdc(8'hd1, 16'h21f0);
      i_smart_dac_host.wr(8'hd3, 16'h5000);
      i_smart_dac_host.wr(8'hd1, 16'h01f0);
      g = 16'h01f0;
      chk_dec;
      check(locked_r, 1'b0);
      i_smart_dac_host.wr(8'h25, 16'd800);
      i_smart_dac_host.wr(8'h26, 16'd16);
      rdc(8'h25, 16'd800);
      rdc(8'h26, 16'd16);
      for (k = 0; k < 8; k = k + 1) begin
         inc = (k < 4) ? k + 1 : (k == 4) ? 6 : (k == 5) ? 8 : (k == 6) ? 16 : 32;
         i_smart_dac_host.wr(8'hd1, {k[1:0], 2'b00, k[2:0], 4'hf, 5'h00});
         run_gen(1'b1);
         p = code_r;
         bad = 0;
         sh = 0;
         sl = 0;
         for (n = 0; n < 420; n = n + 1) begin
            @(negedge sys_clk);
            c = code_r;
            sh = sh | (c == 200);
            sl = sl | (c == 4);
            if (c < 4 || c > 200)
               bad = 1;
            case (k[1:0])
               2'd0: if (c - p > inc || p - c > inc) bad = 1;
               2'd1: if ((c < p || c - p > inc) && c != 4) bad = 1;
               2'd2: if ((c > p || p - c > inc) && c != 200) bad = 1;
               default: if (c != 4 && c != 200) bad = 1;
            endcase
            p = c;
         end
         check({sh[0], sl[0], bad[0]}, 3'b110);
         run_gen(1'b0);
      end
      for (k = 0; k < 2; k = k + 1) begin
         i_smart_dac_host.wr(8'hd1, k ? 16'h0160 : 16'h01c0);
         run_gen(1'b1);
         p = code_r;
         for (n = 0; n < 300 && code_r == p; n = n + 1) @(negedge sys_clk);
         p = code_r;
         for (n = 0; n < 300 && code_r == p; n = n + 1) @(negedge sys_clk);
         check(n, k ? TL : 100);
         run_gen(1'b0);
      end
      // no-slew triangle keeps the update flag up; writes must bounce
      i_smart_dac_host.wr(8'hd1, 16'h01e0);
      run_gen(1'b1);
      rdc(8'hd0, {4'h1, 6'h00, PID, RID});
      i_smart_dac_host.wr(8'hd1, 16'h0000);
      rdc(8'hd1, 16'h01e0);
      run_gen(1'b0);
      end_of_test;
   end
endmodule // smart_dac_status_config_regs_tb
